// ### rtl/plf_lock_fuse.sv
// Operation
// RULE_01: Programmer loads lock-write command first
// RULE_02: Zero data bits program lock bits
// RULE_03: Full lock blocks boot lock programming
// RULE_04: Programmer pulses write, waits for ready
// RULE_05: Lock bits clear only by chip erase
// RULE_06: Programmer loads fuse-read command first
// RULE_07: Selects 00 drive low fuse byte
// RULE_08: Selects 11 drive high fuse byte
// RULE_09: High=1 low=0 drive extended fuses
// RULE_10: High=0 low=1 drive lock bits
// RULE_11: Zero on bus means programmed
// RULE_12: Programmer ends readback with enable high
// RULE_13: Command persists; bus released when disabled
// RULE_14: Ready low from strobe until write done
`timescale 1ns/1ps
module plf_lock_fuse
    import plf_pkg::*;
#(
    parameter int WRITE_CNT = WRITE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cmd_load,
    input  wire logic       data_load,
    input  wire logic [7:0] data_in,
    input  wire logic       write_n,
    input  wire logic       output_en_n,
    input  wire logic       byte_select_low,
    input  wire logic       byte_select_high,
    input  wire logic       chip_erase,
    input  wire logic [7:0] fuse_low,
    input  wire logic [7:0] fuse_high,
    input  wire logic [7:0] fuse_ext,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            ready_busy_out,
    output logic      [7:0] lock_bits
);
    // Counter is 16 bits wide and needs at least one busy cycle
    if (WRITE_CNT < 1 || WRITE_CNT > 65535) begin : g_bad_write_cnt
        $error("WRITE_CNT out of range");
    end

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        plf_state_t  st;
        logic [7:0]  cmd;
        logic [7:0]  wdata;
        logic [7:0]  lock;
        logic [15:0] cnt;
        logic        wr_prev;
        logic [7:0]  dout;
        logic        oe;
    } plf_regs_t;

    plf_regs_t regs_ff;
    plf_regs_t nxt_regs;

    function automatic logic [7:0] plf_read_sel(
        input logic       hi,
        input logic       lo,
        input logic [7:0] fl,
        input logic [7:0] fh,
        input logic [7:0] fe,
        input logic [7:0] lk
    );
        case ({hi, lo})
            2'b00:   plf_read_sel = fl; // RULE_07
            2'b11:   plf_read_sel = fh; // RULE_08
            2'b10:   plf_read_sel = fe; // RULE_09
            default: plf_read_sel = lk; // RULE_10
        endcase
    endfunction

    logic       full_lock;
    logic [7:0] prog_mask;
    logic       wr_fall;

    assign full_lock = ~regs_ff.lock[LOCK_ONE_POS]
                     & ~regs_ff.lock[LOCK_TWO_POS]; // RULE_03
    assign wr_fall   = regs_ff.wr_prev & ~write_n;

    always_comb begin
        prog_mask = ~regs_ff.wdata; // RULE_02
        if (full_lock) begin
            prog_mask = prog_mask & ~BOOT_LOCK_MASK; // RULE_03
        end
    end

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        nxt_regs         = regs_ff;
        nxt_regs.wr_prev = write_n;
        if (cmd_load && regs_ff.st == PLF_IDLE) begin
            nxt_regs.cmd = data_in; // RULE_13
        end
        if (data_load && regs_ff.st == PLF_IDLE) begin
            nxt_regs.wdata = data_in;
        end
        case (regs_ff.st)
            PLF_IDLE: begin
                if (chip_erase) begin
                    nxt_regs.lock = ERASED_BYTE; // RULE_05
                end else if (wr_fall && regs_ff.cmd == CMD_LOCK_WRITE) begin
                    nxt_regs.st  = PLF_BUSY; // RULE_14
                    nxt_regs.cnt = 16'(WRITE_CNT - 1);
                end
            end
            PLF_BUSY: begin
                if (regs_ff.cnt == 16'h0000) begin
                    // Only clears bits: lock-write cannot unprogram
                    nxt_regs.lock = regs_ff.lock & ~prog_mask; // RULE_05
                    nxt_regs.st   = PLF_IDLE; // RULE_14
                end else begin
                    nxt_regs.cnt = regs_ff.cnt - 16'h0001;
                end
            end
            default: nxt_regs.st = PLF_IDLE;
        endcase
        nxt_regs.oe = ~output_en_n && regs_ff.cmd == CMD_FUSE_READ; // RULE_13
        nxt_regs.dout = plf_read_sel(byte_select_high, byte_select_low,
                                     fuse_low, fuse_high, fuse_ext,
                                     regs_ff.lock); // RULE_11
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regs_ff.st      <= PLF_IDLE;
            regs_ff.cmd     <= CMD_RESET_VAL;
            regs_ff.wdata   <= ERASED_BYTE;
            regs_ff.lock    <= ERASED_BYTE;
            regs_ff.cnt     <= 16'h0000;
            regs_ff.wr_prev <= 1'b1;
            regs_ff.dout    <= 8'h00;
            regs_ff.oe      <= 1'b0;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign data_out       = regs_ff.dout;
    assign data_oe        = regs_ff.oe;
    assign ready_busy_out = (regs_ff.st == PLF_IDLE);
    assign lock_bits      = regs_ff.lock;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    property p_busy_on_write;
        @(posedge clk) disable iff (rst)
        (regs_ff.st == PLF_IDLE && !chip_erase && wr_fall
         && regs_ff.cmd == CMD_LOCK_WRITE) |=> !ready_busy_out;
    endproperty
    a_busy_on_write: assert property (p_busy_on_write) // RULE_14
        else $error("ready not low after write strobe");

    property p_lock_monotone;
        @(posedge clk) disable iff (rst)
        !$past(chip_erase) |-> ((lock_bits & ~$past(lock_bits)) == 8'h00);
    endproperty
    a_lock_monotone: assert property (p_lock_monotone) // RULE_05
        else $error("lock bit unprogrammed without erase");

    property p_boot_guard;
        @(posedge clk) disable iff (rst)
        (full_lock && !chip_erase) |=>
            ((lock_bits & BOOT_LOCK_MASK) ==
             ($past(lock_bits) & BOOT_LOCK_MASK));
    endproperty
    a_boot_guard: assert property (p_boot_guard) // RULE_03
        else $error("boot lock changed under full lock");

    property p_release_bus;
        @(posedge clk) disable iff (rst)
        output_en_n |=> !data_oe;
    endproperty
    a_release_bus: assert property (p_release_bus) // RULE_13
        else $error("bus driven while enable inactive");

    property p_read_low;
        @(posedge clk) disable iff (rst)
        (!output_en_n && !byte_select_high && !byte_select_low)
        |=> data_out == $past(fuse_low);
    endproperty
    a_read_low: assert property (p_read_low) // RULE_07
        else $error("low fuse byte wrong");

    property p_read_high;
        @(posedge clk) disable iff (rst)
        (!output_en_n && byte_select_high && byte_select_low)
        |=> data_out == $past(fuse_high);
    endproperty
    a_read_high: assert property (p_read_high) // RULE_08
        else $error("high fuse byte wrong");

    property p_read_ext;
        @(posedge clk) disable iff (rst)
        (!output_en_n && byte_select_high && !byte_select_low)
        |=> data_out == $past(fuse_ext);
    endproperty
    a_read_ext: assert property (p_read_ext) // RULE_09
        else $error("extended fuse byte wrong");

    property p_read_lock;
        @(posedge clk) disable iff (rst)
        (!output_en_n && !byte_select_high && byte_select_low)
        |=> data_out == $past(lock_bits);
    endproperty
    a_read_lock: assert property (p_read_lock) // RULE_10
        else $error("lock byte wrong");

    property p_program_zero;
        @(posedge clk) disable iff (rst)
        (regs_ff.st == PLF_BUSY && regs_ff.cnt == 16'h0000 && !full_lock)
        |=> lock_bits == ($past(lock_bits) & $past(regs_ff.wdata));
    endproperty
    a_program_zero: assert property (p_program_zero) // RULE_02
        else $error("lock write result wrong");

    c_write: cover property (@(posedge clk) disable iff (rst)
        !ready_busy_out ##1 ready_busy_out);
    c_read: cover property (@(posedge clk) disable iff (rst) data_oe);
    c_full: cover property (@(posedge clk) disable iff (rst) full_lock);
endmodule

// ### include/plf_pkg.sv
package plf_pkg;
    // -------------------------------------------------------------------
    // Commands
    // -------------------------------------------------------------------
    localparam logic [7:0] CMD_LOCK_WRITE  = 8'h20;
    localparam logic [7:0] CMD_FUSE_READ   = 8'h04;
    localparam logic [7:0] CMD_RESET_VAL   = 8'h00;
    // -------------------------------------------------------------------
    // Lock byte layout (0 = programmed)
    // -------------------------------------------------------------------
    localparam int         LOCK_ONE_POS    = 0;
    localparam int         LOCK_TWO_POS    = 1;
    localparam logic [7:0] BOOT_LOCK_MASK  = 8'h3c;
    localparam logic [7:0] ERASED_BYTE     = 8'hff;
    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         WRITE_TIME_NS   = 4500;
    localparam int         WRITE_CYCLES    =
        (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // -------------------------------------------------------------------
    // States
    // -------------------------------------------------------------------
    typedef enum logic [0:0] {
        PLF_IDLE,
        PLF_BUSY
    } plf_state_t;
endpackage

// ### dv/plf_prog_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Programmer model
// ---------------------------------------------------------------------
module plf_prog_model
    import plf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       ready_busy_out,
    output logic            cmd_load,
    output logic            data_load,
    output logic      [7:0] data_in,
    output logic            write_n,
    output logic            output_en_n,
    output logic            byte_select_low,
    output logic            byte_select_high
);
    initial begin
        cmd_load = 1'b0;
        data_load = 1'b0;
        data_in = 8'h5a;
        write_n = 1'b1;
        output_en_n = 1'b1;
        byte_select_low = 1'b0;
        byte_select_high = 1'b0;
    end
    task automatic load(input logic c, input logic [7:0] v);
        @(negedge clk);
        cmd_load = c;
        data_load = !c;
        data_in = v;
        @(negedge clk);
        cmd_load = 1'b0;
        data_load = 1'b0;
        data_in = ~v;
    endtask
    task automatic sel(input logic n, input logic hi, input logic lo);
        output_en_n = n;
        byte_select_high = hi;
        byte_select_low = lo;
        @(negedge clk);
    endtask
    task automatic write_lock(input logic [7:0] d, output int low);
        low = 0;
        load(1'b1, CMD_LOCK_WRITE);
        load(1'b0, d);
        write_n = 1'b0;
        @(negedge clk);
        write_n = 1'b1;
        for (int i = 0; i < 64; i++) begin
            if (ready_busy_out === 1'b0) low++;
            else if (low > 0) break;
            @(negedge clk);
        end
    endtask
endmodule

// ### dv/parallel_lock_fuse_access_bench.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Bench
// ---------------------------------------------------------------------
module parallel_lock_fuse_access_bench
    import plf_pkg::*;
;
    localparam int BENCH_WRITE_CNT = 4;
    logic       clk;
    logic       rst;
    logic       chip_erase;
    logic [7:0] fuse_low  = 8'h62;
    logic [7:0] fuse_high = 8'hd9;
    logic [7:0] fuse_ext  = 8'hfd;
    logic       cmd_load, data_load, write_n, output_en_n;
    logic       byte_select_low, byte_select_high;
    logic [7:0] data_in, data_out, lock_bits, exp;
    logic       data_oe, ready_busy_out;
    int         mismatches, checks, low;
    plf_lock_fuse #(.WRITE_CNT(BENCH_WRITE_CNT)) plf_lock_fuse_i (
        .clk(clk), .rst(rst), .cmd_load(cmd_load), .data_load(data_load),
        .data_in(data_in), .write_n(write_n), .output_en_n(output_en_n),
        .byte_select_low(byte_select_low),
        .byte_select_high(byte_select_high), .chip_erase(chip_erase),
        .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext),
        .data_out(data_out), .data_oe(data_oe),
        .ready_busy_out(ready_busy_out), .lock_bits(lock_bits));
    plf_prog_model plf_prog_model_i (
        .clk(clk), .ready_busy_out(ready_busy_out), .cmd_load(cmd_load),
        .data_load(data_load), .data_in(data_in), .write_n(write_n),
        .output_en_n(output_en_n), .byte_select_low(byte_select_low),
        .byte_select_high(byte_select_high));
    task automatic cmp(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] d);
        plf_prog_model_i.write_lock(d, low);
        cmp(low[7:0], 8'(BENCH_WRITE_CNT));
        if (exp[1:0] == 2'b00) exp = exp & (d | BOOT_LOCK_MASK);
        else exp = exp & d;
        cmp(lock_bits, exp);
    endtask
    task automatic rd(input logic hi, input logic lo, input logic [7:0] w);
        plf_prog_model_i.sel(1'b0, hi, lo);
        cmp(data_out, w);
        cmp({7'h00, data_oe}, 8'h01);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        chip_erase = 1'b0;
        mismatches = 0;
        checks = 0;
        exp = ERASED_BYTE;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cmp(lock_bits, ERASED_BYTE);
        cmp({7'h00, ready_busy_out}, 8'h01);
        plf_prog_model_i.load(1'b1, CMD_FUSE_READ);
        rd(1'b0, 1'b0, fuse_low);
        rd(1'b1, 1'b1, fuse_high);
        rd(1'b1, 1'b0, fuse_ext);
        rd(1'b0, 1'b1, exp);
        plf_prog_model_i.sel(1'b1, 1'b0, 1'b0);
        cmp({7'h00, data_oe}, 8'h00);
        wr(8'hfb);
        wr(8'hfe);
        wr(8'hfd);
        wr(8'hc3);
        wr(8'hff);
        plf_prog_model_i.load(1'b1, CMD_FUSE_READ);
        rd(1'b0, 1'b1, exp);
        rd(1'b0, 1'b0, fuse_low);
        plf_prog_model_i.load(1'b1, CMD_LOCK_WRITE);
        plf_prog_model_i.sel(1'b0, 1'b0, 1'b0);
        cmp({7'h00, data_oe}, 8'h00);
        plf_prog_model_i.sel(1'b1, 1'b0, 1'b0);
        chip_erase = 1'b1;
        @(negedge clk);
        chip_erase = 1'b0;
        @(negedge clk);
        cmp(lock_bits, ERASED_BYTE);
        stop_test();
    end
    initial begin
        #20000;
        mismatches++;
        stop_test();
    end
endmodule
